// >>> src/pcfg_port.sv
/*
 eight-pin configurable i/o port with alternate functions.
 assumes mode bits and latch come from software, peripherals on the same clock,
 and a board resolver that forms each pin level from the enables.
*/
`timescale 1ns/1ns
`include "pcfg_params.svh"

module pcfg_port
    import pcfg_pkg::*;
#(
    parameter int WIDTH = `PCFG_WIDTH
) (
    input  wire logic             sys_clk_in,
    input  wire logic             rst_b_in,
    input  wire logic [WIDTH-1:0] pin_mode_select_a_in,
    input  wire logic [WIDTH-1:0] pin_mode_select_b_in,
    input  wire logic [WIDTH-1:0] port_latch_in,
    input  wire logic             can_tx_en_in,
    input  wire logic             can_tx_in,
    input  wire logic             i2c_scl_drive_low_in,
    input  wire logic             i2c_sda_drive_low_in,
    input  wire logic             prog_mode_in,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] pin_out,
    output logic      [WIDTH-1:0] pin_oe_out,
    output logic      [WIDTH-1:0] pin_pullup_out,
    output logic      [WIDTH-1:0] port_read_out,
    output logic                  can_rx_in_out,
    output logic      [3:0]       capture_out,
    output logic      [3:0]       ext_irq_out,
    output logic      [5:0]       analog_sel_out,
    output logic                  i2c_scl_out,
    output logic                  i2c_sda_out,
    output logic      [WIDTH-1:0] prog_addr_lo_out
);
    // elaboration check: pin positions are fixed for an eight-pin port
    if (WIDTH != `PCFG_WIDTH) begin : gen_width_check
        $error("pcfg_port serves exactly eight pins");
    end

    ////////////////////////////////////////////////////////////////////////////
    // input synchroniser
    logic [WIDTH-1:0] pin_sync;

    pcfg_sync #(
        .WIDTH      (WIDTH)
    ) u_sync (
        .sys_clk_in (sys_clk_in),
        .rst_b_in   (rst_b_in),
        .async_in   (pin_in),
        .sync_out   (pin_sync)
    );

    ////////////////////////////////////////////////////////////////////////////
    // registered state: effective mode bits, output value, strong-high pulse
    logic [WIDTH-1:0] mode_a_q;
    logic [WIDTH-1:0] mode_a_d;
    logic [WIDTH-1:0] mode_b_q;
    logic [WIDTH-1:0] mode_b_d;
    logic [WIDTH-1:0] out_q;
    logic [WIDTH-1:0] out_d;
    logic [WIDTH-1:0] strong_q;
    logic [WIDTH-1:0] strong_d;
    logic [WIDTH-1:0] read_q;
    logic [WIDTH-1:0] read_d;
    logic [WIDTH-1:0] addr_q;
    logic [WIDTH-1:0] addr_d;
    logic             run_q;
    logic             run_d;

    always_comb begin
        mode_a_d = pin_mode_select_a_in;
        mode_b_d = pin_mode_select_b_in;
        // i2c pins: force quasi to hiz and push-pull to open drain
        mode_a_d[`PCFG_BIT_SCL] = 1'b1;
        mode_a_d[`PCFG_BIT_SDA] = 1'b1;
        out_d = port_latch_in;
        if (can_tx_en_in) begin
            out_d[`PCFG_BIT_CAN_TX] = can_tx_in;
        end
        out_d[`PCFG_BIT_SCL] = port_latch_in[`PCFG_BIT_SCL] & ~i2c_scl_drive_low_in;
        out_d[`PCFG_BIT_SDA] = port_latch_in[`PCFG_BIT_SDA] & ~i2c_sda_drive_low_in;
        if (prog_mode_in) begin
            // programmer owns the pins: release all drivers
            mode_a_d = {WIDTH{1'b1}};
            mode_b_d = '0;
        end
        // one-cycle strong high on a quasi pin going low to high
        strong_d = out_d & ~out_q;
        read_d   = pin_sync;
        addr_d   = prog_mode_in ? pin_sync : addr_q;
        run_d    = 1'b1;
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            mode_a_q <= '0;
            mode_b_q <= '0;
            out_q    <= '1;
            strong_q <= '0;
            read_q   <= '1;
            addr_q   <= '0;
            run_q    <= 1'b0;
        end else begin
            mode_a_q <= mode_a_d;
            mode_b_q <= mode_b_d;
            out_q    <= out_d;
            strong_q <= strong_d;
            read_q   <= read_d;
            addr_q   <= addr_d;
            run_q    <= run_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pad drivers
    pcfg_pin_if #(.WIDTH(WIDTH)) pins ();

    assign pins.mode_a    = mode_a_q;
    assign pins.mode_b    = mode_b_q;
    assign pins.out_val   = out_q;
    assign pins.strong_hi = strong_q;

    pcfg_pad u_pad (
        .pins (pins)
    );

    ////////////////////////////////////////////////////////////////////////////
    // outputs; reset held combinationally so it acts without a clock
    logic rst_now;
    assign rst_now = ~rst_b_in | ~run_q;

    always_comb begin
        if (rst_now) begin
            pin_oe_out     = '0;
            pin_pullup_out = WIDTH'(`PCFG_RESET_PULL);
        end else begin
            pin_oe_out     = pins.drv_oe;
            pin_pullup_out = pins.weak_pull;
        end
    end

    assign pin_out          = out_q;
    assign port_read_out    = read_q;
    assign can_rx_in_out    = read_q[`PCFG_BIT_CAN_RX];
    assign capture_out      = read_q[`PCFG_BIT_CAP_HI:`PCFG_BIT_CAP_LO];
    assign ext_irq_out      = read_q[`PCFG_BIT_CAP_HI:`PCFG_BIT_CAP_LO];
    assign analog_sel_out   = mode_a_q[`PCFG_BIT_ANA_HI:`PCFG_BIT_ANA_LO]
                            & ~mode_b_q[`PCFG_BIT_ANA_HI:`PCFG_BIT_ANA_LO];
    assign i2c_scl_out      = read_q[`PCFG_BIT_SCL];
    assign i2c_sda_out      = read_q[`PCFG_BIT_SDA];
    assign prog_addr_lo_out = addr_q;
endmodule

// >>> shared/pcfg_params.svh
/*
 port configuration constants: mode codes, pin positions, sync reset value.
 assumes inclusion by bare name from the package and the modules.
*/
`ifndef PCFG_PARAMS_SVH
`define PCFG_PARAMS_SVH
`define PCFG_WIDTH       8
`define PCFG_MODE_QUASI  2'b00
`define PCFG_MODE_PUSH   2'b01
`define PCFG_MODE_HIZ    2'b10
`define PCFG_MODE_OPEN   2'b11
`define PCFG_BIT_CAN_RX  0
`define PCFG_BIT_CAN_TX  1
`define PCFG_BIT_CAP_LO  2
`define PCFG_BIT_CAP_HI  5
`define PCFG_BIT_ANA_LO  2
`define PCFG_BIT_ANA_HI  7
`define PCFG_BIT_SCL     6
`define PCFG_BIT_SDA     7
`define PCFG_RESET_PULL  8'h03
`define PCFG_WEAK_HOLD   2'h2
`define PCFG_SYNC_INIT   8'hff
`endif

// >>> shared/pcfg_pkg.sv
/*
 types for the port configuration block.
 assumes pcfg_params.svh is on the include path.
*/
`include "pcfg_params.svh"
package pcfg_pkg;
    typedef enum logic [1:0] {
        PCFG_QUASI_E = 2'b00,
        PCFG_PUSH_E  = 2'b01,
        PCFG_HIZ_E   = 2'b10,
        PCFG_OPEN_E  = 2'b11
    } pcfg_mode_e;
    typedef logic [`PCFG_WIDTH-1:0] pcfg_byte_t;
endpackage

// >>> shared/pcfg_pin_if.sv
/*
 per-pin drive controls passed from the port top to the pad driver.
 assumes one clock domain; no timing inside.
*/
`timescale 1ns/1ns
interface pcfg_pin_if #(parameter int WIDTH = 8);
    logic [WIDTH-1:0] mode_a;
    logic [WIDTH-1:0] mode_b;
    logic [WIDTH-1:0] out_val;
    logic [WIDTH-1:0] strong_hi;
    logic [WIDTH-1:0] drv_oe;
    logic [WIDTH-1:0] weak_pull;
    modport ctrl (output mode_a, output mode_b, output out_val, output strong_hi,
                  input drv_oe, input weak_pull);
    modport pad  (input mode_a, input mode_b, input out_val, input strong_hi,
                  output drv_oe, output weak_pull);
endinterface

// >>> src/pcfg_sync.sv
/*
 two-flop synchroniser for the port pin inputs.
 assumes asynchronous inputs; only the second stage is read outside.
*/
`timescale 1ns/1ns
`include "pcfg_params.svh"
module pcfg_sync
    import pcfg_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input  wire logic             sys_clk_in,
    input  wire logic             rst_b_in,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    // elaboration check: at least one bit to synchronise
    if (WIDTH < 1) begin : gen_width_check
        $error("pcfg_sync needs at least one bit");
    end

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] stab_q;
    logic [WIDTH-1:0] stab_d;

    always_comb begin
        meta_d = async_in;
        stab_d = meta_q;
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            meta_q <= WIDTH'(`PCFG_SYNC_INIT);
            stab_q <= WIDTH'(`PCFG_SYNC_INIT);
        end else begin
            meta_q <= meta_d;
            stab_q <= stab_d;
        end
    end

    assign sync_out = stab_q;
endmodule

// >>> src/pcfg_pad.sv
/*
 per-pin pad driver: turns mode bits and output value into enables.
 assumes the top gates reset and the i2c pin restrictions.
*/
`timescale 1ns/1ns
`include "pcfg_params.svh"
module pcfg_pad
    import pcfg_pkg::*;
(
    pcfg_pin_if.pad pins
);
    function automatic logic drive_on(input logic [1:0] m, input logic v, input logic s);
        case (m)
            `PCFG_MODE_PUSH:  drive_on = 1'b1;
            `PCFG_MODE_OPEN:  drive_on = ~v;
            `PCFG_MODE_QUASI: drive_on = ~v | s;
            `PCFG_MODE_HIZ:   drive_on = 1'b0;
            default:          drive_on = 1'b0;
        endcase
    endfunction

    always_comb begin
        for (int i = 0; i < $bits(pins.drv_oe); i++) begin
            pins.drv_oe[i]    = drive_on({pins.mode_a[i], pins.mode_b[i]},
                                         pins.out_val[i], pins.strong_hi[i]);
            pins.weak_pull[i] = ({pins.mode_a[i], pins.mode_b[i]} == `PCFG_MODE_QUASI);
        end
    end
endmodule

// >>> test/pcfg_port_props.sv
/* port checker on pcfg_port ports.
 assumes one clock, async active-low reset. */
`timescale 1ns/1ns
module pcfg_port_props
    import pcfg_pkg::*;
(
    input wire logic       sys_clk_in,
    input wire logic       rst_b_in,
    input wire logic [7:0] pin_mode_select_a_in,
    input wire logic [7:0] pin_mode_select_b_in,
    input wire logic       prog_mode_in,
    input wire logic [7:0] pin_in,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe_out,
    input wire logic [7:0] pin_pullup_out,
    input wire logic [7:0] port_read_out,
    input wire logic       can_rx_in_out,
    input wire logic [3:0] capture_out,
    input wire logic [3:0] ext_irq_out,
    input wire logic       i2c_scl_out,
    input wire logic       i2c_sda_out,
    input wire logic [7:0] prog_addr_lo_out
);
    logic [1:0] cnt_q;
    logic [1:0] cnt_d;
    logic [7:0] run_w;
    logic [7:0] hiz_w;
    logic [7:0] pp_w;
    logic [7:0] od_w;
    logic [7:0] q_w;
    assign run_w = {2'h0, {6{~prog_mode_in}}};
    assign hiz_w = pin_mode_select_a_in & ~pin_mode_select_b_in & run_w;
    assign pp_w = ~pin_mode_select_a_in & pin_mode_select_b_in & run_w;
    assign od_w = pin_mode_select_a_in & pin_mode_select_b_in & run_w;
    assign q_w = ~pin_mode_select_a_in & ~pin_mode_select_b_in & run_w;
    always_comb begin
        cnt_d = (cnt_q == 2'h3) ? cnt_q : cnt_q + 2'h1;
    end
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cnt_q <= 2'h0;
        end else begin
            cnt_q <= cnt_d;
        end
    end
    ////////////////////////////////////////////////////////////////
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rst_b_in);
    chk_reset_pull: assert property ($rose(rst_b_in) |->
        pin_pullup_out == 8'h03 && pin_oe_out == 8'h00) else $error("reset pins wrong");
    chk_hiz_float: assert property (cnt_q[1] |->
        (pin_oe_out & $past(hiz_w)) == 8'h00) else $error("hiz pin driven");
    chk_push_drive: assert property (cnt_q[1] |->
        (pin_oe_out & $past(pp_w)) == $past(pp_w)) else $error("push pin not driven");
    chk_od_drive: assert property (cnt_q[1] |->
        ((pin_oe_out ^ ~pin_out) & $past(od_w)) == 8'h00) else $error("open drain wrong");
    chk_quasi_pull: assert property (cnt_q[1] |->
        (pin_pullup_out & $past(q_w)) == $past(q_w)) else $error("quasi pull missing");
    chk_i2c_limit: assert property (cnt_q[1] |-> pin_pullup_out[7:6] == 2'h0 &&
        (pin_oe_out[7:6] & pin_out[7:6]) == 2'h0) else $error("i2c pin driven high");
    chk_read_delay: assert property (cnt_q == 2'h3 |->
        port_read_out == $past(pin_in, 3)) else $error("read latency wrong");
    chk_alt_route: assert property (cnt_q == 2'h3 |->
        can_rx_in_out == port_read_out[0] && capture_out == port_read_out[5:2] &&
        ext_irq_out == port_read_out[5:2] &&
        {i2c_sda_out, i2c_scl_out} == port_read_out[7:6]) else $error("alt route wrong");
    chk_prog_off: assert property (prog_mode_in |=>
        pin_oe_out == 8'h00) else $error("pin driven in prog");
    chk_prog_addr: assert property (cnt_q == 2'h3 && $past(prog_mode_in) &&
        $past(prog_mode_in, 2) |-> prog_addr_lo_out == $past(pin_in, 3))
        else $error("prog address wrong");
endmodule
bind pcfg_port pcfg_port_props u_props (.sys_clk_in, .rst_b_in, .pin_mode_select_a_in,
    .pin_mode_select_b_in, .prog_mode_in, .pin_in, .pin_out, .pin_oe_out, .pin_pullup_out,
    .port_read_out, .can_rx_in_out, .capture_out, .ext_irq_out, .i2c_scl_out,
    .i2c_sda_out, .prog_addr_lo_out);

// >>> test/pcfg_board.sv
/* board model: resolves pin levels from enables and outside drivers.
 assumes bench sets the outside drivers; loose pins toggle. */
`timescale 1ns/1ns
module pcfg_board (
    input  wire logic       sys_clk_in,
    input  wire logic [7:0] pin_val_in,
    input  wire logic [7:0] pin_oe_in,
    input  wire logic [7:0] pullup_in,
    input  wire logic [7:0] ext_en_in,
    input  wire logic [7:0] ext_val_in,
    output logic      [7:0] level_out
);
    logic [7:0] float_q;
    initial begin
        float_q = 8'h00;
    end
    always @(posedge sys_clk_in) begin
        float_q <= ~float_q;
    end
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pin_oe_in[i]) begin
                level_out[i] = pin_val_in[i];
            end else if (ext_en_in[i]) begin
                level_out[i] = ext_val_in[i];
            end else if (pullup_in[i]) begin
                level_out[i] = 1'b1;
            end else begin
                level_out[i] = float_q[i];
            end
        end
    end
endmodule

// >>> test/pcfg_port_tb.sv
/* self-checking bench for pcfg_port.
 assumes the checker is bound in. */
`timescale 1ns/1ns
module pcfg_port_tb
    import pcfg_pkg::*;
;
    logic clk, rst_b, can_en, can_tx, scl_lo, sda_lo, prog, can_rx, scl, sda;
    pcfg_byte_t a, b, lat, ext_en, ext_val, lvl, po, oe, pu, rd, addr, ea, e_oe;
    logic [3:0] cap, irq;
    logic [5:0] ana;
    logic [1:0] code;
    int n_mismatch = 0;
    int num_checks = 0;
    pcfg_board board (.sys_clk_in(clk), .pin_val_in(po), .pin_oe_in(oe), .pullup_in(pu),
        .ext_en_in(ext_en), .ext_val_in(ext_val), .level_out(lvl));
    pcfg_port dut (.sys_clk_in(clk), .rst_b_in(rst_b), .pin_mode_select_a_in(a),
        .pin_mode_select_b_in(b), .port_latch_in(lat), .can_tx_en_in(can_en),
        .can_tx_in(can_tx), .i2c_scl_drive_low_in(scl_lo), .i2c_sda_drive_low_in(sda_lo),
        .prog_mode_in(prog), .pin_in(lvl), .pin_out(po), .pin_oe_out(oe),
        .pin_pullup_out(pu), .port_read_out(rd), .can_rx_in_out(can_rx),
        .capture_out(cap), .ext_irq_out(irq), .analog_sel_out(ana), .i2c_scl_out(scl),
        .i2c_sda_out(sda), .prog_addr_lo_out(addr));
    ////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(negedge clk);
    endtask
    task print_verdict;
        $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        clk = 0;
        forever #4 clk = ~clk;
    end
    initial begin
        #16000;
        n_mismatch++;
        print_verdict;
    end
    initial begin
        {rst_b, can_en, can_tx, scl_lo, sda_lo, prog} = 6'h00;
        {a, b, lat, ext_en, ext_val} = 40'h0;
        step(5);
        check(oe, 8'h00);
        check(pu, 8'h03);
        step(1);
        rst_b = 1;
        for (int r = 0; r < 8; r++) begin
            for (int i = 0; i < 8; i++) begin
                code = 2'((i + r) % 4);
                a[i] = code[1];
                b[i] = code[0];
            end
            lat = {8{r[2]}};
            step(1);
            if (r == 4) begin
                check(oe & pu, pu);
            end
            step(2);
            ea = a | 8'hc0;
            e_oe = (~ea & b) | (~(ea ^ b) & ~lat);
            check(oe, e_oe);
            check(pu, ~ea & ~b);
            check({2'h0, ana}, {2'h0, ea[7:2] & ~b[7:2]});
        end
        {a, b, ext_en, ext_val} = 32'hff00_ffb7;
        step(4);
        check(rd, 8'hb7);
        check({irq, cap}, 8'hdd);
        check({5'h0, sda, scl, can_rx}, 8'h05);
        {a, b, lat, ext_en} = {8'h00, 8'h02, 8'h00, 8'h00};
        {can_en, can_tx} = 2'h3;
        step(2);
        check({7'h0, po[1]}, 8'h01);
        check({7'h0, oe[1]}, 8'h01);
        can_tx = 0;
        step(2);
        check({7'h0, po[1]}, 8'h00);
        rst_b = 0;
        #1 check(pu, 8'h03);
        check(oe, 8'h00);
        step(1);
        rst_b = 1;
        {a, b, lat} = {8'hc0, 8'hc0, 8'hff};
        {ext_en, ext_val, scl_lo} = {8'hc0, 8'hc0, 1'b1};
        step(4);
        check(oe & 8'hc0, 8'h40);
        check({6'h0, sda, scl}, 8'h02);
        {scl_lo, sda_lo} = 2'h1;
        step(2);
        check(oe & 8'hc0, 8'h80);
        {prog, ext_en, ext_val} = 17'h1_ff5a;
        step(5);
        check(oe, 8'h00);
        check(addr, 8'h5a);
        {prog, ext_val} = 9'h0a5;
        step(5);
        check(addr, 8'h5a);
        print_verdict;
    end
endmodule
